// file: logic/tpc_pkg.sv
`default_nettype none
package tpc_pkg;
    // ==========================================
    // Sizes
    localparam int NUM_CH = 2;
    // ==========================================
    // Register map, byte addresses
    localparam logic [7:0] ADDR_SC = 8'h00;
    localparam logic [7:0] ADDR_CNTH = 8'h04;
    localparam logic [7:0] ADDR_CNTL = 8'h08;
    localparam logic [7:0] ADDR_MODH = 8'h0c;
    localparam logic [7:0] ADDR_MODL = 8'h10;
    localparam logic [7:0] ADDR_PULL = 8'h14;
    localparam logic [7:0] CH_BASE = 8'h20;
    localparam logic [7:0] CH_STRIDE = 8'h10;
    localparam logic [7:0] CH_SC_OFS = 8'h00;
    localparam logic [7:0] CH_VH_OFS = 8'h04;
    localparam logic [7:0] CH_VL_OFS = 8'h08;
    // ==========================================
    // Field codes
    localparam logic [1:0] CLKS_OFF = 2'h0;
    localparam logic [1:0] CLKS_BUS = 2'h1;
    localparam logic [1:0] CLKS_FIXED = 2'h2;
    localparam logic [1:0] CLKS_EXT = 2'h3;
    localparam logic [1:0] ELS_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    localparam logic [1:0] OC_TOGGLE = 2'h1;
    localparam logic [1:0] OC_CLEAR = 2'h2;
    localparam logic [1:0] OC_SET = 2'h3;
    localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;
    // ==========================================
    // Reset values
    localparam logic [7:0] SC_RESET = 8'h00;
    localparam logic [7:0] CH_SC_RESET = 8'h00;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] MOD_RESET = 16'h0000;
    localparam logic [15:0] VAL_RESET = 16'h0000;
    localparam logic [7:0] PULL_RESET = 8'h00;
    // ==========================================
    // Types
    typedef struct packed {
        logic ovf;
        logic ie;
        logic center_aligned_pwm;
        logic [1:0] clks;
        logic [2:0] ps;
    } tpc_sc_t;
    typedef struct packed {
        logic flag;
        logic ie;
        logic [1:0] ms;
        logic [1:0] els;
        logic [1:0] rsv;
    } tpc_csc_t;
    typedef enum logic [3:0] {
        MODE_CAPTURE = 4'b0001,
        MODE_COMPARE = 4'b0010,
        MODE_EDGE_PWM = 4'b0100,
        MODE_CENTER = 4'b1000
    } tpc_mode_t;
endpackage
`default_nettype wire

// file: logic/tpc_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [RL1] 16-bit counter: free, modulo or up/down.
// [RL2] Modulo 0 or all ones runs full range.
// [RL3] Counter write clears count.
// [RL4] Counter reads never disturb counting.
// [RL5] Up-counter is every channel's time base.
// [RL6] Clock code 11 selects pin clock.
// [RL7] Pin clock is synchronised first.
// [RL8] Pin clock at most quarter bus rate.
// [RL9] Prescale ratios 1 to 128.
// [RL10] Fixed clock: oscillator/2 when locked, else bus.
// [RL11] Reset leaves timer off, pins plain inputs.
// [RL12] Pullup allowed on timer input pins.
// [RL13] Clock pin channel has edge/level bits 00.
// [RL14] That channel still times by compare.
// [RL15] Owned pins ignore port data and direction.
// [RL16] Unused pins return to general I/O.
// [RL17] One bit sets center PWM on all channels.
// [RL18] Channel is capture, compare or edge PWM.
// [RL19] Capture on rise, fall or both.
// [RL20] Compare sets, clears, toggles; PWM polarity.
// [RL21] Interrupt per channel plus overflow.
// [RL22] 8-bit controls, 16-bit count, modulo, values.
// [RL23] Clock codes: off, bus, fixed, pin.
// [RL24] Prescale codes 0..7 divide 1..128.
// [RL25] Overflow at wrap, or step down in center.
// [RL26] Counter byte read latches both bytes.
// [RL27] Center mode counts up to modulo and down.
module tpc_timer (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_count_clock,
    input wire logic oscillator_reference_clock,
    input wire logic external_reference_locked_mode,
    input wire logic [tpc_pkg::NUM_CH-1:0] channel_pin_in,
    output logic [tpc_pkg::NUM_CH-1:0] channel_pin_out,
    output logic [tpc_pkg::NUM_CH-1:0] channel_pin_oe,
    output logic [tpc_pkg::NUM_CH-1:0] channel_pin_owned,
    output logic [tpc_pkg::NUM_CH-1:0] channel_pin_pullup,
    output logic overflow_irq,
    output logic [tpc_pkg::NUM_CH-1:0] channel_irq
);
    localparam int N = tpc_pkg::NUM_CH;

    // ==========================================
    // APB handshake
    logic setup_acc;
    logic wr_go;
    logic rd_go;
    logic [7:0] wb;
    // One wait state; all side effects happen on the first access edge
    assign setup_acc = psel & penable & ~pready;
    assign wr_go = setup_acc & pwrite;
    assign rd_go = setup_acc & ~pwrite;
    assign wb = pwdata[7:0];

    // ==========================================
    // Address decode
    logic hit_sc;
    logic hit_cnth;
    logic hit_cntl;
    logic hit_modh;
    logic hit_modl;
    logic hit_pull;
    logic [N-1:0] hit_csc;
    logic [N-1:0] hit_cvh;
    logic [N-1:0] hit_cvl;
    logic addr_hit;
    assign hit_sc = paddr == tpc_pkg::ADDR_SC;
    assign hit_cnth = paddr == tpc_pkg::ADDR_CNTH;
    assign hit_cntl = paddr == tpc_pkg::ADDR_CNTL;
    assign hit_modh = paddr == tpc_pkg::ADDR_MODH;
    assign hit_modl = paddr == tpc_pkg::ADDR_MODL;
    assign hit_pull = paddr == tpc_pkg::ADDR_PULL;
    assign addr_hit = hit_sc | hit_cnth | hit_cntl | hit_modh | hit_modl
        | hit_pull | (|hit_csc) | (|hit_cvh) | (|hit_cvl);

    // ==========================================
    // Synchronisers for pins from outside the clock domain
    logic [2:0] ext_sync;
    logic [2:0] osc_sync;
    logic [1:0] lock_sync;
    logic [N-1:0] pin_s0;
    logic [N-1:0] pin_s1;
    logic [N-1:0] pin_prev;
    // Stage zero feeds stage one only
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ext_sync <= 3'h0;
            osc_sync <= 3'h0;
            lock_sync <= 2'h0;
            pin_s0 <= '0;
            pin_s1 <= '0;
            pin_prev <= '0;
        end else begin
            ext_sync <= {ext_sync[1:0], external_count_clock}; // [RL7]
            osc_sync <= {osc_sync[1:0], oscillator_reference_clock};
            lock_sync <= {lock_sync[0], external_reference_locked_mode};
            pin_s0 <= channel_pin_in;
            pin_s1 <= pin_s0;
            pin_prev <= pin_s1;
        end
    end

    // ==========================================
    // Module control register
    tpc_pkg::tpc_sc_t sc;
    logic ovf_armed;
    logic run;
    assign run = sc.clks != tpc_pkg::CLKS_OFF; // [RL11]

    // ==========================================
    // Clock source and prescaler
    logic ext_rise;
    logic osc_rise;
    logic fixed_half;
    logic fixed_tick;
    logic src_tick;
    logic [6:0] pre;
    logic [6:0] pre_mask;
    logic cnt_tick;
    // Pin clock is only safe up to a quarter of bus rate
    assign ext_rise = ext_sync[1] & ~ext_sync[2]; // [RL8]
    assign osc_rise = osc_sync[1] & ~osc_sync[2];
    // Locked mode halves the oscillator; otherwise same as bus rate
    assign fixed_tick = lock_sync[1] ? (osc_rise & fixed_half)
        : 1'b1; // [RL10]
    always_comb begin
        unique case (sc.clks) // [RL23]
            tpc_pkg::CLKS_BUS: src_tick = 1'b1;
            tpc_pkg::CLKS_FIXED: src_tick = fixed_tick;
            tpc_pkg::CLKS_EXT: src_tick = ext_rise; // [RL6]
            default: src_tick = 1'b0;
        endcase
    end
    // Tick when the low ps prescaler bits roll over
    assign pre_mask = 7'(8'hff >> (4'h8 - {1'b0, sc.ps})); // [RL24]
    assign cnt_tick = src_tick & ((pre & pre_mask) == pre_mask); // [RL9]
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pre <= 7'h00;
            fixed_half <= 1'b0;
        end else begin
            if (src_tick)
                pre <= pre + 7'h01;
            if (osc_rise)
                fixed_half <= ~fixed_half;
        end
    end

    // ==========================================
    // Counter
    logic [15:0] cnt;
    logic [15:0] modv;
    logic [15:0] top;
    logic cnt_down;
    logic [15:0] next_cnt;
    logic next_down;
    logic ovf_evt;
    logic cnt_wr;
    logic step_q;
    logic wrap_q;
    assign cnt_wr = wr_go & (hit_cnth | hit_cntl);
    // Both extremes of the modulo mean full range
    assign top = (modv == 16'h0000 || modv == tpc_pkg::COUNT_ALL_ONES)
        ? tpc_pkg::COUNT_ALL_ONES : modv; // [RL2]
    always_comb begin
        next_cnt = cnt;
        next_down = cnt_down;
        ovf_evt = 1'b0;
        if (!sc.center_aligned_pwm) begin
            // Up-count wraps to zero after top
            if (cnt == top) begin
                next_cnt = 16'h0000;
                ovf_evt = 1'b1; // [RL25]
            end else begin
                next_cnt = cnt + 16'h0001; // [RL1]
            end
        end else if (!cnt_down) begin
            // Center mode turns at top and flags the step down
            if (cnt >= top) begin
                next_cnt = cnt - 16'h0001; // [RL27]
                next_down = 1'b1;
                ovf_evt = 1'b1; // [RL25]
            end else begin
                next_cnt = cnt + 16'h0001;
            end
        end else begin
            if (cnt == 16'h0000) begin
                next_cnt = 16'h0001; // [RL27]
                next_down = 1'b0;
            end else begin
                next_cnt = cnt - 16'h0001;
            end
        end
    end
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt <= tpc_pkg::CNT_RESET;
            cnt_down <= 1'b0;
            step_q <= 1'b0;
            wrap_q <= 1'b0;
        end else begin
            step_q <= cnt_tick & ~cnt_wr;
            wrap_q <= cnt_tick & ~cnt_wr & ovf_evt & ~sc.center_aligned_pwm;
            if (cnt_wr) begin
                cnt <= tpc_pkg::CNT_RESET; // [RL3]
                cnt_down <= 1'b0;
            end else if (cnt_tick) begin
                cnt <= next_cnt;
                cnt_down <= next_down;
            end
        end
    end

    // ==========================================
    // Coherent counter read buffer
    logic cnt_latched;
    logic first_high;
    logic [15:0] cnt_buf;
    logic [7:0] cnth_rd;
    logic [7:0] cntl_rd;
    // Reads only touch the buffer, never the running count
    assign cnth_rd = cnt_latched ? cnt_buf[15:8] : cnt[15:8]; // [RL4]
    assign cntl_rd = cnt_latched ? cnt_buf[7:0] : cnt[7:0];
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_latched <= 1'b0;
            first_high <= 1'b0;
            cnt_buf <= tpc_pkg::CNT_RESET;
        end else if (cnt_wr || (wr_go && hit_sc)) begin
            cnt_latched <= 1'b0;
        end else if (rd_go && (hit_cnth || hit_cntl)) begin
            if (!cnt_latched) begin
                cnt_latched <= 1'b1; // [RL26]
                cnt_buf <= cnt;
                first_high <= hit_cnth;
            end else if (first_high != hit_cnth) begin
                cnt_latched <= 1'b0; // [RL26]
            end
        end
    end

    // ==========================================
    // Control, modulo and pullup registers
    logic [N-1:0] pull_en;
    logic sc_wr_clr;
    // Clear needs a read with the flag set, then a write of 0
    assign sc_wr_clr = wr_go & hit_sc & ~wb[7] & ovf_armed;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sc <= tpc_pkg::tpc_sc_t'(tpc_pkg::SC_RESET);
            ovf_armed <= 1'b0;
            modv <= tpc_pkg::MOD_RESET;
            pull_en <= N'(tpc_pkg::PULL_RESET);
        end else begin
            if (wr_go && hit_sc) begin
                sc.ie <= wb[6];
                sc.center_aligned_pwm <= wb[5]; // [RL17]
                sc.clks <= wb[4:3];
                sc.ps <= wb[2:0];
            end
            // A new overflow wins over a clear in the same cycle
            if (cnt_tick && !cnt_wr && ovf_evt)
                sc.ovf <= 1'b1;
            else if (sc_wr_clr)
                sc.ovf <= 1'b0;
            if (cnt_tick && !cnt_wr && ovf_evt)
                ovf_armed <= 1'b0;
            else if (rd_go && hit_sc && sc.ovf)
                ovf_armed <= 1'b1;
            else if (wr_go && hit_sc)
                ovf_armed <= 1'b0;
            if (wr_go && hit_modh)
                modv[15:8] <= wb;
            if (wr_go && hit_modl)
                modv[7:0] <= wb;
            if (wr_go && hit_pull)
                pull_en <= wb[N-1:0]; // [RL12]
        end
    end

    // ==========================================
    // Channels
    logic [7:0] ch_rd [N];
    logic [N-1:0] ch_flag_ie;
    logic [N-1:0] ch_out;
    logic [N-1:0] ch_own;
    logic [N-1:0] ch_oe;
    logic [N-1:0] ch_pull;
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_ch
            localparam logic [7:0] BASE = 8'(tpc_pkg::CH_BASE
                + gi * tpc_pkg::CH_STRIDE);
            tpc_pkg::tpc_csc_t csc;
            tpc_pkg::tpc_mode_t mode;
            logic [15:0] val;
            logic armed;
            logic rise;
            logic fall;
            logic cap_evt;
            logic match;
            logic act;
            logic next_out;
            logic out_q;
            logic flag_set;
            logic flag_clr;
            assign hit_csc[gi] = paddr == BASE + tpc_pkg::CH_SC_OFS;
            assign hit_cvh[gi] = paddr == BASE + tpc_pkg::CH_VH_OFS;
            assign hit_cvl[gi] = paddr == BASE + tpc_pkg::CH_VL_OFS;
            // Center bit overrides every channel's own mode
            assign mode = sc.center_aligned_pwm ? tpc_pkg::MODE_CENTER // [RL17]
                : csc.ms[1] ? tpc_pkg::MODE_EDGE_PWM // [RL18]
                : csc.ms[0] ? tpc_pkg::MODE_COMPARE
                : tpc_pkg::MODE_CAPTURE;
            assign rise = pin_s1[gi] & ~pin_prev[gi];
            assign fall = ~pin_s1[gi] & pin_prev[gi];
            assign cap_evt = run && mode == tpc_pkg::MODE_CAPTURE
                && ((csc.els == tpc_pkg::EDGE_RISE && rise)
                || (csc.els == tpc_pkg::EDGE_FALL && fall)
                || (csc.els == tpc_pkg::EDGE_BOTH
                && (rise || fall))); // [RL19]
            // Matches are checked on the count just taken
            assign match = step_q && cnt == val // [RL5]
                && mode != tpc_pkg::MODE_CAPTURE;
            assign act = ~csc.els[0]; // [RL20]
            always_comb begin
                next_out = out_q;
                unique case (mode)
                    tpc_pkg::MODE_COMPARE: begin
                        if (match && csc.els == tpc_pkg::OC_TOGGLE)
                            next_out = ~out_q; // [RL20]
                        else if (match && csc.els == tpc_pkg::OC_CLEAR)
                            next_out = 1'b0;
                        else if (match && csc.els == tpc_pkg::OC_SET)
                            next_out = 1'b1;
                    end
                    tpc_pkg::MODE_EDGE_PWM: begin
                        // Match beats wrap so value 0 gives 0% duty
                        if (match)
                            next_out = ~act;
                        else if (wrap_q)
                            next_out = act;
                    end
                    tpc_pkg::MODE_CENTER: begin
                        next_out = (cnt < val) ? act : ~act;
                    end
                    tpc_pkg::MODE_CAPTURE: begin
                        next_out = 1'b0;
                    end
                endcase
            end
            // Flag needs no pin, so a clock-pin channel still times
            assign flag_set = cap_evt | match; // [RL14]
            assign flag_clr = wr_go & hit_csc[gi] & ~wb[7] & armed;
            always_ff @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    csc <= tpc_pkg::tpc_csc_t'(tpc_pkg::CH_SC_RESET);
                    val <= tpc_pkg::VAL_RESET;
                    armed <= 1'b0;
                    out_q <= 1'b0;
                end else begin
                    out_q <= next_out;
                    if (wr_go && hit_csc[gi]) begin
                        csc.ie <= wb[6];
                        csc.ms <= wb[5:4];
                        csc.els <= wb[3:2];
                    end
                    if (flag_set)
                        csc.flag <= 1'b1;
                    else if (flag_clr)
                        csc.flag <= 1'b0;
                    if (flag_set)
                        armed <= 1'b0;
                    else if (rd_go && hit_csc[gi] && csc.flag)
                        armed <= 1'b1;
                    else if (wr_go && hit_csc[gi])
                        armed <= 1'b0;
                    // Capture wins over a software write of the value
                    if (cap_evt)
                        val <= cnt; // [RL19]
                    else if (wr_go && hit_cvh[gi])
                        val[15:8] <= wb; // [RL22]
                    else if (wr_go && hit_cvl[gi])
                        val[7:0] <= wb;
                end
            end
            assign ch_rd[gi] = hit_csc[gi] ? 8'(csc)
                : hit_cvh[gi] ? val[15:8]
                : hit_cvl[gi] ? val[7:0] : 8'h00;
            assign ch_flag_ie[gi] = csc.flag & csc.ie;
            assign ch_out[gi] = out_q;
            // Pin belongs to the timer only when the channel uses it
            assign ch_own[gi] = run
                && csc.els != tpc_pkg::ELS_NONE; // [RL16]
            assign ch_oe[gi] = ch_own[gi]
                && mode != tpc_pkg::MODE_CAPTURE;
            assign ch_pull[gi] = ch_own[gi] && pull_en[gi]
                && mode == tpc_pkg::MODE_CAPTURE; // [RL12]
        end
    endgenerate

    // ==========================================
    // Read data select
    logic [7:0] ch_any_rd;
    logic [7:0] rd_byte;
    always_comb begin
        ch_any_rd = 8'h00;
        for (int i = 0; i < N; i++)
            ch_any_rd = ch_any_rd | ch_rd[i];
    end
    assign rd_byte = hit_sc ? 8'(sc)
        : hit_cnth ? cnth_rd
        : hit_cntl ? cntl_rd
        : hit_modh ? modv[15:8]
        : hit_modl ? modv[7:0]
        : hit_pull ? 8'(pull_en) : ch_any_rd;

    // ==========================================
    // Registered outputs
    // Owned pins: port data and direction have no say over them
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            channel_pin_out <= '0;
            channel_pin_oe <= '0;
            channel_pin_owned <= '0;
            channel_pin_pullup <= '0;
            overflow_irq <= 1'b0;
            channel_irq <= '0;
        end else begin
            pready <= setup_acc;
            pslverr <= setup_acc & ~addr_hit;
            if (rd_go)
                prdata <= {24'h00_0000, rd_byte};
            channel_pin_out <= ch_out;
            channel_pin_oe <= ch_oe;
            channel_pin_owned <= ch_own; // [RL15]
            channel_pin_pullup <= ch_pull;
            overflow_irq <= sc.ovf & sc.ie; // [RL21]
            channel_irq <= ch_flag_ie; // [RL21]
        end
    end
endmodule
`default_nettype wire

// file: tb/tpc_timer_props.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port relations of the timer
module tpc_timer_props (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [tpc_pkg::NUM_CH-1:0] channel_pin_oe,
    input wire logic [tpc_pkg::NUM_CH-1:0] channel_pin_owned,
    input wire logic [tpc_pkg::NUM_CH-1:0] channel_pin_pullup
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // A transfer is taken at its first access edge
    sequence take_s;
        psel && penable && !pready;
    endsequence
    sequence miss_s;
        take_s ##0 (paddr == 8'h18 || paddr >= 8'h40);
    endsequence
    // Bus answer and read data
    answer_once_a: assert property (take_s |=> pready ##1 !pready)
        else $error("transfer not answered after one wait state");
    err_miss_a: assert property (miss_s |=> pslverr)
        else $error("unmapped address not refused");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error flag without ready");
    byte_wide_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("read data above the byte not zero");
    rdata_hold_a: assert property (
        !(psel && penable && !pready && !pwrite) |=> $stable(prdata))
        else $error("read data moved without a read");
    // Pin ownership
    oe_owned_a: assert property (
        (channel_pin_oe & ~channel_pin_owned) == 0)
        else $error("pin driven while not owned");
    pull_input_a: assert property (
        (channel_pin_pullup & channel_pin_oe) == 0)
        else $error("pullup on a driven pin");
    reset_idle_a: assert property (disable iff (1'b0) sys_rst |=>
        channel_pin_owned == 0 && channel_pin_oe == 0 && channel_pin_pullup == 0)
        else $error("pins not released after reset");
endmodule
bind tpc_timer tpc_timer_props tpc_timer_props_inst (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .channel_pin_oe(channel_pin_oe), .channel_pin_owned(channel_pin_owned),
    .channel_pin_pullup(channel_pin_pullup));
`default_nettype wire

// file: tb/tpc_pins.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Far side: channel pins and external count clock
module tpc_pins (
    input wire logic sys_clk,
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe,
    input wire logic [1:0] pin_pullup,
    input wire logic [1:0] level,
    input wire logic [1:0] drive,
    output logic [1:0] pin_in,
    output logic ext_clk
);
    logic [1:0] held = 2'h0;
    // Timer drive wins; a floating pin never keeps a stale level
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : drive[i] ? level[i]
                : pin_pullup[i] ? 1'b1 : ~held[i];
        end
    end
    always @(posedge sys_clk) held <= pin_in;
    initial ext_clk = 1'b0;
    // Clock stands still between frames; eight bus cycles a period
    task automatic pulses(input int cnt);
        repeat (cnt) begin
            repeat (4) @(posedge sys_clk);
            ext_clk <= 1'b1;
            repeat (4) @(posedge sys_clk);
            ext_clk <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// file: tb/tpc_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tpc_timer_tb;
    typedef struct {logic [7:0] a, d, e; logic er;} tpc_row_t;
    tpc_row_t rows [6] = '{'{8'h0c, 8'h12, 8'h12, 0}, '{8'h10, 8'h34, 8'h34, 0},
        '{8'h34, 8'h56, 8'h56, 0}, '{8'h38, 8'h9a, 8'h9a, 0},
        '{8'h14, 8'h03, 8'h03, 0}, '{8'h18, 8'h5a, 8'h00, 1}};
    logic sys_clk, sys_rst, psel, penable, pwrite, osc, er, ext, oirq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr;
    logic [15:0] cv;
    logic [1:0] lvl, drv, pin_in, pin_out, oe, own, pull, cirq;
    logic [2:0] ev;
    int errors = 0, checks = 0, cyc = 0;
    assign ev = {cirq, oirq};
    // ==========================================
    // Clock, oscillator and hang guard
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always #37 osc = ~osc;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            errors++;
            end_of_test;
        end
    end
    tpc_timer tpc_timer_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_count_clock(ext), .oscillator_reference_clock(osc),
        .external_reference_locked_mode(1'b0), .channel_pin_in(pin_in),
        .channel_pin_out(pin_out), .channel_pin_oe(oe),
        .channel_pin_owned(own), .channel_pin_pullup(pull),
        .overflow_irq(oirq), .channel_irq(cirq));
    tpc_pins tpc_pins_inst (.sys_clk(sys_clk), .pin_out(pin_out),
        .pin_oe(oe), .pin_pullup(pull), .level(lvl), .drive(drv),
        .pin_in(pin_in), .ext_clk(ext));
    // ==========================================
    // Bus, compare and closing tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One transfer, then an idle edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic cnt;
        apb(0, 8'h08, 0);
        cv[7:0] = rd[7:0];
        apb(0, 8'h04, 0);
        cv[15:8] = rd[7:0];
    endtask
    task automatic wt(input int k);
        for (int n = 0; n < 200 && ev[k] !== 1'b1; n++) @(posedge sys_clk);
        @(posedge sys_clk);
    endtask
    task automatic end_of_test;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata, osc, lvl, drv} = '0;
        sys_rst = 1'b1;
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        chk({oe, own, pull, cirq, oirq}, 0);
        apb(0, 8'h00, 0);
        chk(rd, 0);
        foreach (rows[i]) begin
            apb(1, rows[i].a, rows[i].d);
            apb(0, rows[i].a, 0);
            chk({er, rd}, {rows[i].er, 24'h0, rows[i].e});
        end
        // Every divider, then fixed clock, which equals bus rate here
        for (int i = 0; i < 9; i++) begin
            apb(1, 8'h00, i < 8 ? 8'h08 | i : 8'h10);
            apb(1, 8'h04, 0);
            repeat (64 << (i % 8)) @(posedge sys_clk);
            cnt;
            chk(cv >= 63 && cv <= 72, 1);
        end
        apb(1, 8'h0c, 8'hff);
        apb(1, 8'h10, 8'hff);
        apb(1, 8'h08, 8'h5a);
        apb(0, 8'h04, 0);
        repeat (300) @(posedge sys_clk);
        apb(0, 8'h08, 0);
        chk(rd < 16, 1);
        cnt;
        chk(cv > 300 && cv < 330, 1);
        // Up count reads low after wrap; center count reads near modulo
        apb(1, 8'h0c, 0);
        apb(1, 8'h10, 8'h10);
        apb(1, 8'h04, 0);
        for (int c = 0; c < 2; c++) begin
            apb(1, 8'h00, 8'h48 | c << 5);
            wt(0);
            apb(0, 8'h00, 0);
            apb(1, 8'h00, 8'h48 | c << 5);
            wt(0);
            apb(0, 8'h08, 0);
            chk({rd < 8, rd <= 16}, {c == 0, 1'b1});
        end
        apb(1, 8'h00, 8'h08);
        apb(1, 8'h28, 8'h08);
        for (int k = 3; k >= 0; k--) begin
            apb(0, 8'h20, 0);
            apb(1, 8'h20, 8'h50 | k << 2);
            wt(1);
            chk({cirq[0], own[0] && oe[0]}, {1'b1, k != 0});
            if (k > 0) chk(pin_out[0], k != 2);
        end
        for (int k = 1; k < 4; k++) begin
            lvl[1] <= (k == 2);
            drv[1] <= 1'b1;
            apb(0, 8'h30, 0);
            apb(1, 8'h30, 8'h40 | k << 2);
            chk(pull[1], 1);
            lvl[1] <= (k != 2);
            wt(2);
            chk(cirq[1], 1);
        end
        apb(1, 8'h30, 8'h00);
        apb(1, 8'h10, 8'h00);
        apb(1, 8'h00, 8'h18);
        apb(1, 8'h04, 0);
        tpc_pins_inst.pulses(40);
        repeat (8) @(posedge sys_clk);
        cnt;
        chk(cv, 40);
        end_of_test;
    end
endmodule
`default_nettype wire
